// file: verilog/csdc_pkg.sv
// Register map, field layout, state types and decoders of the clock select and doze controller.
// Assumes an AXI4-Lite master with 32-bit data and a CPU core that reports events as pulses.
// Operation
// - Frequency codes 0000..1000 give 1,2,4,8,12,16,32,48,64 MHz; others reserved.
// - Frequency field reset value is supplied by hardware at each reset.
// - Reference source: sysclk, fast, slow 31k, mid 500k, secondary; 101..111 none.
// - Idle enable set: sleep stops only the CPU clock, peripherals keep running.
// - Idle enable clear: sleep stops the whole device.
// - Idle enable clears on power-on and brown-out reset, kept on others.
// - Slowdown enabled: CPU cycles only at ratio; disabled: every cycle.
// - Ratio 000 gives 1:2, each step doubles, 111 gives 1:256.
// - Recover-on-interrupt set: interrupt entry clears the slowdown enable.
// - Slowdown-on-exit set: interrupt return sets the slowdown enable.
// - Debug forces full CPU speed without touching the stored slowdown enable.
package csdc_pkg;
    localparam int unsigned ADDR_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_FREQ = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_REF_SRC = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_REF_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CPU = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;

    // ------------------------------------------------------------
    // Fields, masks and reset values
    // ------------------------------------------------------------
    localparam int unsigned BIT_IDLE = 7;
    localparam int unsigned BIT_CPU_SLOWDOWN_ENABLE = 6;
    localparam int unsigned BIT_ROI = 5;
    localparam int unsigned BIT_DOE = 4;
    localparam int unsigned BIT_REF_EN = 7;
    localparam int unsigned STAT_MHZ_LSB = 8;
    localparam logic [7:0] MASK_REF_CTRL = 8'h9F;
    localparam logic [7:0] RST_REF_CTRL = 8'h00;
    localparam logic [2:0] RST_REF_SRC = 3'h0;
    localparam logic [2:0] RST_RATIO = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [2:0] SRC_SYS = 3'h0;
    localparam logic [2:0] SRC_FAST = 3'h1;
    localparam logic [2:0] SRC_SLOW = 3'h2;
    localparam logic [2:0] SRC_MID = 3'h3;
    localparam logic [2:0] SRC_SEC = 3'h4;

    typedef enum logic [2:0] {
        REG_FREQ = 3'b000,
        REG_REF_SRC = 3'b001,
        REG_REF_CTRL = 3'b010,
        REG_CPU = 3'b011,
        REG_STATUS = 3'b100,
        REG_NONE = 3'b101
    } csdc_reg_t;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_IDLE = 2'b01,
        PWR_SLEEP = 2'b10
    } csdc_pwr_t;

    typedef struct packed {
        logic sec;
        logic mid;
        logic slow;
        logic fast;
        logic sys;
    } csdc_osc_t;

    typedef struct packed {
        logic sleep_exec;
        logic irq_entry;
        logic irq_return;
        logic wake;
    } csdc_evt_t;

    typedef struct packed {
        logic [3:0] freq;
        logic [2:0] ref_src;
        logic [7:0] ref_ctrl;
        logic idle_en;
        logic cpu_slowdown_enable;
        logic wake_full_speed_on_irq;
        logic slowdown_on_irq_return;
        logic [2:0] ratio;
        csdc_pwr_t pwr;
        logic [6:0] mhz;
        logic ref_out;
        logic aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic w_held;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } csdc_state_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic cycle;
    } csdc_div_state_t;

    function automatic csdc_reg_t reg_decode(input logic [ADDR_W-1:0] addr);
        if (addr == OFF_FREQ) return REG_FREQ;
        else if (addr == OFF_REF_SRC) return REG_REF_SRC;
        else if (addr == OFF_REF_CTRL) return REG_REF_CTRL;
        else if (addr == OFF_CPU) return REG_CPU;
        else if (addr == OFF_STATUS) return REG_STATUS;
        else return REG_NONE;
    endfunction

    function automatic logic [6:0] freq_mhz(input logic [3:0] code);
        case (code)
            4'h0: return 7'h01;
            4'h1: return 7'h02;
            4'h2: return 7'h04;
            4'h3: return 7'h08;
            4'h4: return 7'h0C;
            4'h5: return 7'h10;
            4'h6: return 7'h20;
            4'h7: return 7'h30;
            4'h8: return 7'h40;
            default: return 7'h00;
        endcase
    endfunction
endpackage

// file: verilog/csdc_doze_div.sv
// Slowdown divider: passes one CPU instruction cycle per 2^(ratio+1) peripheral cycles.
// Assumes periph_cycle is a one-cycle pulse synchronous to aclk.
module csdc_doze_div (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic periph_cycle, // Peripheral instruction cycle pulse
    input wire logic run, // CPU clock running
    input wire logic doze_on, // Effective slowdown enable
    input wire logic [2:0] ratio, // Slowdown ratio code
    output logic cpu_cycle // CPU instruction cycle pulse
);
    csdc_pkg::csdc_div_state_t q, d;
    logic [7:0] lim;

    assign lim = 8'((16'h0002 << ratio) - 16'h0001);

    always_comb begin
        d = q;
        d.cycle = 1'b0;
        if (!doze_on) begin
            d.cnt = 8'h00;
            d.cycle = periph_cycle & run;
        end else if (periph_cycle) begin
            d.cycle = run & (q.cnt == 8'h00);
            // Ratio may shrink below count, so wrap on greater-or-equal
            d.cnt = (q.cnt >= lim) ? 8'h00 : 8'(q.cnt + 8'h01);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cpu_cycle = q.cycle;

    property p_div_wrap;
        @(posedge aclk) disable iff (!aresetn)
        doze_on && periph_cycle && q.cnt >= lim |=> q.cnt == 8'h00;
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap");

    property p_div_hold;
        @(posedge aclk) disable iff (!aresetn)
        doze_on && periph_cycle && q.cnt != 8'h00 |=> !cpu_cycle;
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("cpu cycle inside slowdown gap");
endmodule

// file: verilog/csdc_top.sv
// Clock select and doze controller: oscillator frequency, reference mux, CPU slowdown and idle.
// Assumes one clock, sampled oscillator levels and CPU event pulses synchronous to aclk.
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
module csdc_top (
    input wire logic aclk, // System clock, 50 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic por_bor, // Current reset is power-on or brown-out
    input wire logic [3:0] freq_reset_code, // Hardware frequency code for reset
    input wire logic [csdc_pkg::ADDR_W-1:0] awaddr, // AXI write address
    input wire logic awvalid, // AXI write address valid
    output logic awready, // AXI write address ready
    input wire logic [31:0] wdata, // AXI write data
    input wire logic [3:0] wstrb, // AXI write strobes
    input wire logic wvalid, // AXI write data valid
    output logic wready, // AXI write data ready
    output logic [1:0] bresp, // AXI write response
    output logic bvalid, // AXI write response valid
    input wire logic bready, // AXI write response ready
    input wire logic [csdc_pkg::ADDR_W-1:0] araddr, // AXI read address
    input wire logic arvalid, // AXI read address valid
    output logic arready, // AXI read address ready
    output logic [31:0] rdata, // AXI read data
    output logic [1:0] rresp, // AXI read response
    output logic rvalid, // AXI read valid
    input wire logic rready, // AXI read ready
    input csdc_pkg::csdc_osc_t osc_src, // Sampled oscillator levels
    input csdc_pkg::csdc_evt_t cpu_evt, // CPU event pulses
    input wire logic periph_cycle, // Peripheral instruction cycle pulse
    input wire logic debug_active, // In-circuit debug active
    output logic [3:0] fast_osc_freq_select, // Fast oscillator code
    output logic [6:0] fast_osc_mhz, // Fast oscillator nominal MHz
    output logic ref_clk_out, // Reference output level
    output logic cpu_clk_run, // CPU clock enabled
    output logic periph_clk_run, // Peripheral clocks enabled
    output logic device_sleep, // Whole device in sleep
    output logic cpu_cycle_en // CPU instruction cycle pulse
);
    csdc_pkg::csdc_state_t q, d;
    logic doze_on;
    logic run;

    // ------------------------------------------------------------
    // Slowdown divider
    // ------------------------------------------------------------
    // debug override, stored bit untouched
    assign doze_on = q.cpu_slowdown_enable & ~debug_active;
    assign run = (q.pwr == csdc_pkg::PWR_RUN);

    csdc_doze_div u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .periph_cycle(periph_cycle),
        .run(run),
        .doze_on(doze_on),
        .ratio(q.ratio),
        .cpu_cycle(cpu_cycle_en)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        csdc_pkg::csdc_reg_t wsel;
        csdc_pkg::csdc_reg_t rsel;
        logic [31:0] rd;
        logic src;
        wsel = csdc_pkg::REG_NONE;
        rsel = csdc_pkg::REG_NONE;
        rd = 32'h0000_0000;
        src = 1'b0;
        d = q;

        // Bus write channels, taken in either order
        if (awvalid && awready) begin
            d.aw_held = 1'b1;
            d.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            d.w_held = 1'b1;
            d.wdata = wdata[7:0];
            d.wstrb0 = wstrb[0];
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_held && q.w_held && !q.bvalid) begin
            wsel = csdc_pkg::reg_decode(q.awaddr);
            d.aw_held = 1'b0;
            d.w_held = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = (wsel == csdc_pkg::REG_NONE) ? csdc_pkg::RESP_SLVERR : csdc_pkg::RESP_OKAY;
            if (q.wstrb0) begin
                if (wsel == csdc_pkg::REG_FREQ) begin
                    d.freq = q.wdata[3:0];
                end else if (wsel == csdc_pkg::REG_REF_SRC) begin
                    d.ref_src = q.wdata[2:0];
                end else if (wsel == csdc_pkg::REG_REF_CTRL) begin
                    d.ref_ctrl = q.wdata & csdc_pkg::MASK_REF_CTRL;
                end else if (wsel == csdc_pkg::REG_CPU) begin
                    d.idle_en = q.wdata[csdc_pkg::BIT_IDLE];
                    d.cpu_slowdown_enable = q.wdata[csdc_pkg::BIT_CPU_SLOWDOWN_ENABLE];
                    d.wake_full_speed_on_irq = q.wdata[csdc_pkg::BIT_ROI];
                    d.slowdown_on_irq_return = q.wdata[csdc_pkg::BIT_DOE];
                    d.ratio = q.wdata[2:0];
                end
            end
        end

        // Hardware updates follow the write so an event is never lost to it
        // interrupt entry clears
        if (cpu_evt.irq_entry && q.wake_full_speed_on_irq) begin
            d.cpu_slowdown_enable = 1'b0;
        end
        if (cpu_evt.irq_return && q.slowdown_on_irq_return) begin
            d.cpu_slowdown_enable = 1'b1;
        end

        // Sleep and idle sequencing
        case (q.pwr)
            csdc_pkg::PWR_RUN: begin
                if (cpu_evt.sleep_exec) begin
                    d.pwr = q.idle_en ? csdc_pkg::PWR_IDLE : csdc_pkg::PWR_SLEEP;
                end
            end
            csdc_pkg::PWR_IDLE, csdc_pkg::PWR_SLEEP: begin
                if (cpu_evt.wake) begin
                    d.pwr = csdc_pkg::PWR_RUN;
                end
            end
            default: begin
                d.pwr = csdc_pkg::PWR_RUN;
            end
        endcase

        d.mhz = csdc_pkg::freq_mhz(q.freq);

        case (q.ref_src)
            csdc_pkg::SRC_SYS: src = osc_src.sys;
            csdc_pkg::SRC_FAST: src = osc_src.fast;
            csdc_pkg::SRC_SLOW: src = osc_src.slow;
            csdc_pkg::SRC_MID: src = osc_src.mid;
            csdc_pkg::SRC_SEC: src = osc_src.sec;
            default: src = 1'b0;
        endcase
        d.ref_out = src & q.ref_ctrl[csdc_pkg::BIT_REF_EN];

        // Bus read channel
        if (arvalid && arready) begin
            rsel = csdc_pkg::reg_decode(araddr);
            if (rsel == csdc_pkg::REG_FREQ) begin
                rd[3:0] = q.freq;
            end else if (rsel == csdc_pkg::REG_REF_SRC) begin
                rd[2:0] = q.ref_src;
            end else if (rsel == csdc_pkg::REG_REF_CTRL) begin
                rd[7:0] = q.ref_ctrl;
            end else if (rsel == csdc_pkg::REG_CPU) begin
                rd[7:0] = {q.idle_en, q.cpu_slowdown_enable, q.wake_full_speed_on_irq, q.slowdown_on_irq_return, 1'b0, q.ratio};
            end else if (rsel == csdc_pkg::REG_STATUS) begin
                rd[3:0] = {debug_active, doze_on, q.pwr};
                rd[csdc_pkg::STAT_MHZ_LSB +: 7] = q.mhz;
            end
            d.rvalid = 1'b1;
            d.rdata = rd;
            d.rresp = (rsel == csdc_pkg::REG_NONE) ? csdc_pkg::RESP_SLVERR : csdc_pkg::RESP_OKAY;
        end else if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.ref_src <= csdc_pkg::RST_REF_SRC;
            q.ref_ctrl <= csdc_pkg::RST_REF_CTRL;
            q.ratio <= csdc_pkg::RST_RATIO;
            q.pwr <= csdc_pkg::PWR_RUN;
            q.freq <= freq_reset_code;
            // Lookup matches the loaded code, no stale MHz after release
            q.mhz <= csdc_pkg::freq_mhz(freq_reset_code);
            q.idle_en <= por_bor ? 1'b0 : q.idle_en;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // One write and one read in flight; response must drain first
    assign awready = ~q.aw_held & ~q.bvalid;
    assign wready = ~q.w_held & ~q.bvalid;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = ~q.rvalid;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign fast_osc_freq_select = q.freq;
    assign fast_osc_mhz = q.mhz;
    assign ref_clk_out = q.ref_out;
    assign cpu_clk_run = run;
    assign periph_clk_run = (q.pwr != csdc_pkg::PWR_SLEEP);
    assign device_sleep = (q.pwr == csdc_pkg::PWR_SLEEP);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_freq_64;
        @(posedge aclk) disable iff (!aresetn)
        q.freq == 4'h8 ##1 q.freq == 4'h8 |-> fast_osc_mhz == 7'h40;
    endproperty
    a_freq_64: assert property (p_freq_64) else $error("code 1000 not 64 MHz");

    property p_freq_reset;
        @(posedge aclk)
        !aresetn |=> fast_osc_freq_select == $past(freq_reset_code);
    endproperty
    a_freq_reset: assert property (p_freq_reset) else $error("reset freq not loaded");

    property p_ref_sys;
        @(posedge aclk) disable iff (!aresetn)
        q.ref_src == csdc_pkg::SRC_SYS && q.ref_ctrl[csdc_pkg::BIT_REF_EN]
            |=> ref_clk_out == $past(osc_src.sys);
    endproperty
    a_ref_sys: assert property (p_ref_sys) else $error("ref mux not sysclk");

    property p_idle;
        @(posedge aclk) disable iff (!aresetn)
        run && cpu_evt.sleep_exec && q.idle_en |=> !cpu_clk_run && periph_clk_run;
    endproperty
    a_idle: assert property (p_idle) else $error("idle did not keep peripherals");

    property p_sleep;
        @(posedge aclk) disable iff (!aresetn)
        run && cpu_evt.sleep_exec && !q.idle_en |=> device_sleep ##1 !cpu_cycle_en;
    endproperty
    a_sleep: assert property (p_sleep) else $error("full sleep not entered");

    property p_idle_warm;
        @(posedge aclk)
        !aresetn |=> q.idle_en == ($past(por_bor) ? 1'b0 : $past(q.idle_en));
    endproperty
    a_idle_warm: assert property (p_idle_warm) else $error("idle bit reset wrong");

    property p_full_speed;
        @(posedge aclk) disable iff (!aresetn)
        !doze_on && run && periph_cycle |=> cpu_cycle_en;
    endproperty
    a_full_speed: assert property (p_full_speed) else $error("full speed cycle dropped");

    property p_roi;
        @(posedge aclk) disable iff (!aresetn)
        cpu_evt.irq_entry && q.wake_full_speed_on_irq && !(cpu_evt.irq_return && q.slowdown_on_irq_return) |=> !q.cpu_slowdown_enable;
    endproperty
    a_roi: assert property (p_roi) else $error("slowdown kept on irq entry");

    property p_doe;
        @(posedge aclk) disable iff (!aresetn)
        cpu_evt.irq_return && q.slowdown_on_irq_return |=> q.cpu_slowdown_enable;
    endproperty
    a_doe: assert property (p_doe) else $error("slowdown not set on return");

    property p_debug;
        @(posedge aclk) disable iff (!aresetn)
        debug_active && run && periph_cycle |=> cpu_cycle_en;
    endproperty
    a_debug: assert property (p_debug) else $error("debug not full speed");
endmodule

// file: test/csdc_testbench.sv
// Self-checking bench for the clock select and doze controller.
// Assumes csdc_pkg and csdc_top are compiled first; the bench drives every port itself.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic aclk, aresetn, por_bor, awvalid, wvalid, bready, arvalid, rready;
    logic periph_cycle, debug_active;
    logic [3:0] freq_reset_code, wstrb;
    logic [csdc_pkg::ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata;
    csdc_pkg::csdc_osc_t osc_src;
    csdc_pkg::csdc_evt_t cpu_evt;
    logic awready, wready, bvalid, arready, rvalid, ref_clk_out;
    logic cpu_clk_run, periph_clk_run, device_sleep, cpu_cycle_en;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] fast_osc_freq_select;
    logic [6:0] fast_osc_mhz;
    int bad_count = 0;
    int n_tests = 0;

    csdc_top uut (.aclk(aclk), .aresetn(aresetn), .por_bor(por_bor),
        .freq_reset_code(freq_reset_code), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .osc_src(osc_src), .cpu_evt(cpu_evt), .periph_cycle(periph_cycle),
        .debug_active(debug_active), .fast_osc_freq_select(fast_osc_freq_select),
        .fast_osc_mhz(fast_osc_mhz), .ref_clk_out(ref_clk_out), .cpu_clk_run(cpu_clk_run),
        .periph_clk_run(periph_clk_run), .device_sleep(device_sleep),
        .cpu_cycle_en(cpu_cycle_en));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset(input logic por, input logic [3:0] code);
        por_bor <= por;
        freq_reset_code <= code;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    // Master holds each channel until its own ready; no fixed latency assumed
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                @(posedge aclk);
                return;
            end
        end
        bad_count++;
        summarize();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                @(posedge aclk);
                return;
            end
        end
        bad_count++;
        summarize();
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk("bresp", csdc_pkg::RESP_OKAY, r);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(what, exp, d);
        chk("rresp", csdc_pkg::RESP_OKAY, r);
    endtask

    task automatic pulse(input logic [3:0] e);
        cpu_evt <= e;
        @(posedge aclk);
        cpu_evt <= 4'h0;
        #1;
    endtask

    // Counts admitted CPU cycles over n peripheral pulses spaced two clocks apart
    task automatic count_cycles(input int n, output int c);
        c = 0;
        for (int i = 0; i < n; i++) begin
            periph_cycle <= 1'b1;
            @(posedge aclk);
            periph_cycle <= 1'b0;
            #1;
            if (cpu_cycle_en === 1'b1) c++;
            @(posedge aclk);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_chk("freq after por", csdc_pkg::OFF_FREQ, 32'h5);
        rd_chk("src after por", csdc_pkg::OFF_REF_SRC, 32'h0);
        rd_chk("cpu after por", csdc_pkg::OFF_CPU, 32'h0);
        wr_ok(csdc_pkg::OFF_CPU, 8'h87);
        do_reset(1'b0, 4'h3);
        rd_chk("freq after warm", csdc_pkg::OFF_FREQ, 32'h3);
        rd_chk("idle kept warm", csdc_pkg::OFF_CPU, 32'h80);
        do_reset(1'b1, 4'h8);
        rd_chk("idle cleared por", csdc_pkg::OFF_CPU, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_freq();
        logic [6:0] mhz [16] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h0C, 7'h10, 7'h20, 7'h30,
            7'h40, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
        for (int c = 0; c < 16; c++) begin
            wr_ok(csdc_pkg::OFF_FREQ, 8'(c));
            rd_chk("freq readback", csdc_pkg::OFF_FREQ, 32'(c));
            repeat (2) @(posedge aclk);
            #1;
            chk("freq select", 32'(c), 32'(fast_osc_freq_select));
            chk("nominal mhz", 32'(mhz[c]), 32'(fast_osc_mhz));
        end
        $display("test freq done");
    endtask

    task automatic t_ref();
        wr_ok(csdc_pkg::OFF_REF_CTRL, 8'h80);
        for (int s = 0; s < 5; s++) begin
            wr_ok(csdc_pkg::OFF_REF_SRC, 8'(s));
            rd_chk("src readback", csdc_pkg::OFF_REF_SRC, 32'(s));
            osc_src <= 5'h01 << s;
            repeat (3) @(posedge aclk);
            #1;
            chk("ref out high", 32'h1, 32'(ref_clk_out));
            osc_src <= ~(5'h01 << s);
            repeat (3) @(posedge aclk);
            #1;
            chk("ref out low", 32'h0, 32'(ref_clk_out));
        end
        wr_ok(csdc_pkg::OFF_REF_SRC, 8'h05);
        osc_src <= 5'h1F;
        repeat (3) @(posedge aclk);
        #1;
        chk("ref out unimpl", 32'h0, 32'(ref_clk_out));
        $display("test ref done");
    endtask

    task automatic t_sleep();
        wr_ok(csdc_pkg::OFF_CPU, 8'h80);
        pulse(4'h8);
        chk("idle cpu run", 32'h0, 32'(cpu_clk_run));
        chk("idle periph run", 32'h1, 32'(periph_clk_run));
        chk("idle no sleep", 32'h0, 32'(device_sleep));
        pulse(4'h1);
        chk("woken cpu run", 32'h1, 32'(cpu_clk_run));
        wr_ok(csdc_pkg::OFF_CPU, 8'h00);
        pulse(4'h8);
        chk("sleep flag", 32'h1, 32'(device_sleep));
        chk("sleep periph", 32'h0, 32'(periph_clk_run));
        chk("sleep cpu", 32'h0, 32'(cpu_clk_run));
        pulse(4'h1);
        $display("test sleep done");
    endtask

    task automatic t_doze();
        int c;
        wr_ok(csdc_pkg::OFF_CPU, 8'h00);
        count_cycles(4, c);
        chk("full speed", 32'd4, 32'(c));
        for (int r = 0; r < 8; r++) begin
            wr_ok(csdc_pkg::OFF_CPU, 8'h40 | 8'(r));
            count_cycles(4 << r, c);
            chk("ratio count", 32'd2, 32'(c));
        end
        debug_active <= 1'b1;
        count_cycles(4, c);
        chk("debug speed", 32'd4, 32'(c));
        rd_chk("status in debug", csdc_pkg::OFF_STATUS, 32'h0000_0008);
        debug_active <= 1'b0;
        rd_chk("debug keeps bit", csdc_pkg::OFF_CPU, 32'h47);
        $display("test doze done");
    endtask

    task automatic t_irq();
        wr_ok(csdc_pkg::OFF_CPU, 8'h60);
        pulse(4'h4);
        rd_chk("roi clears", csdc_pkg::OFF_CPU, 32'h20);
        wr_ok(csdc_pkg::OFF_CPU, 8'h40);
        pulse(4'h4);
        rd_chk("no roi keeps", csdc_pkg::OFF_CPU, 32'h40);
        wr_ok(csdc_pkg::OFF_CPU, 8'h10);
        pulse(4'h2);
        rd_chk("doe sets", csdc_pkg::OFF_CPU, 32'h50);
        wr_ok(csdc_pkg::OFF_CPU, 8'h00);
        pulse(4'h2);
        rd_chk("no doe keeps", csdc_pkg::OFF_CPU, 32'h00);
        $display("test irq done");
    endtask

    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        rd(8'h14, d, r);
        chk("unmapped read", csdc_pkg::RESP_SLVERR, r);
        wr(8'h20, 8'hFF, r);
        chk("unmapped write", csdc_pkg::RESP_SLVERR, r);
        $display("test unmapped done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, periph_cycle, debug_active} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        osc_src = '0;
        cpu_evt = '0;
        aresetn = 1'b0;
        por_bor = 1'b1;
        freq_reset_code = 4'h5;
        @(posedge aclk);
        do_reset(1'b1, 4'h5);
        t_reset();
        t_freq();
        t_ref();
        t_sleep();
        t_doze();
        t_irq();
        t_unmapped();
        summarize();
    end
endmodule
